// [rtl/smbsp_pkg.sv]
// Shared constants, field positions and the CRC helper for both ends of the serial management link.
package smbsp_pkg;
  localparam logic [6:0] DEV_ADDR     = 7'h4C;        // Fixed slave address 1001100.
  localparam logic [6:0] ARA_ADDR     = 7'h0C;        // Alert response address 0001100.
  localparam logic [7:0] CRC_POLY     = 8'h07;        // x8 + x2 + x1 + 1.
  localparam logic [7:0] CFG_OFS      = 8'h00;        // General configuration register one.
  localparam logic [7:0] STATUS_OFS   = 8'h01;        // Sticky out-of-limit status.
  localparam logic [7:0] MASK_OFS     = 8'h02;        // Alert mask.
  localparam logic [7:0] CFG_RESET    = 8'h00;        // Timeout enabled after reset.
  localparam int         TMO_DIS_BIT  = 5;            // Set to disable the inactivity timeout.
  localparam int         CLK_HZ       = 40_000_000;   // Core clock rate.
  localparam int         TMO_MS       = 25;           // Inactivity timeout in milliseconds.
  localparam int         TMO_CYC      = CLK_HZ / 1000 * TMO_MS;
  localparam int         SCL_HZ       = 100_000;      // Host serial clock rate.
  localparam int         QUARTER_CYC  = CLK_HZ / (SCL_HZ * 4);
  localparam logic [3:0] CMD_OFS      = 4'h0;         // Host command register, byte address.
  localparam logic [3:0] HSTAT_OFS    = 4'h4;         // Host status register, byte address.
  localparam int         CMD_PTR_LSB  = 0;            // Pointer byte.
  localparam int         CMD_DATA_LSB = 8;            // Data byte.
  localparam int         CMD_ADDR_LSB = 16;           // Seven-bit slave address.
  localparam int         CMD_READ_BIT = 23;           // Direction: 1 reads one byte.
  localparam int         CMD_TWO_BIT  = 24;           // Write sends the data byte too.
  localparam int         CMD_PEC_BIT  = 25;           // Append or fetch the check byte.
  localparam int         HS_BUSY_BIT  = 0;
  localparam int         HS_NACK_BIT  = 1;
  localparam int         HS_PEC_BIT   = 2;
  localparam int         HS_ALERT_BIT = 3;
  localparam int         HS_RDATA_LSB = 8;

  // One byte folded into a running CRC-8, most significant bit first.
  function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction
endpackage

// [rtl/smbsp_if.sv]
// Open-drain wires joining the controller and the device port.
`timescale 1ns/1ps
interface smbsp_if;
  logic sclOut;      // Host clock drive value, always low.
  logic sclOe;       // Host pulls the clock low.
  logic sdaHostOut;  // Host data drive value, always low.
  logic sdaHostOe;   // Host pulls data low.
  logic sdaDevOut;   // Device data drive value, always low.
  logic sdaDevOe;    // Device pulls data low.
  logic alertOut;    // Device alert drive value, always low.
  logic alertOe;     // Device pulls alert low.
  logic scl;         // Resolved clock wire with pull-up.
  logic sda;         // Resolved data wire with pull-up.
  logic alert_n;     // Resolved alert wire, low when asserted.

  // Wired-AND resolution of every open-drain driver.
  assign scl     = ~(sclOe & ~sclOut);
  assign sda     = ~((sdaHostOe & ~sdaHostOut) | (sdaDevOe & ~sdaDevOut));
  assign alert_n = ~(alertOe & ~alertOut);

  modport device (input scl, input sda, output sdaDevOut, output sdaDevOe, output alertOut, output alertOe);
  modport host (input sda, input alert_n, output sclOut, output sclOe, output sdaHostOut, output sdaHostOe);
endinterface

// [rtl/smbsp_device.sv]
// Contract
// R1 - Start: data falls while clock high
// R2 - Shift eight address bits, MSB first
// R3 - Answer only address 1001100; the code also answers 0001100 on a read while its alert is active
// R4 - Matched address: hold data low for ack
// R5 - Mismatch: stay released until next start
// R6 - Direction zero writes, one reads
// R7 - First written byte loads address pointer
// R8 - Abandon transfer after 25 ms silence
// R9 - Timeout on at reset, config bit5 disables
// R10 - Check byte only when master clocks it
// R11 - Check byte is CRC-8, poly 07
// R12 - Unmasked status bit pulls alert low
// R13 - Mask bits block their status sources
// R14 - Alert is an open-drain output
// R15 - Data open-drain, clock input only
// R16 - Limit outcomes latch into readable status
// R17 - Second written byte goes to selected register
// R18 - Read returns selected register byte
// R19 - Master ends read with nack, stop
// R20 - Alert low: answer alert response address
// R21 - Timeout releases data, returns to idle
`timescale 1ns/1ps
module smbsp_device
  import smbsp_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = smbsp_pkg::TMO_CYC,  // Shorten for simulation.
  parameter int REG_COUNT      = 16                   // General byte registers.
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  smbsp_if.device         bus,
  input  wire logic [7:0] limitIn,
  output logic      [7:0] cfgOut
);
  import smbsp_pkg::*;

  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
  localparam int IW = $clog2(REG_COUNT);

  typedef enum logic [2:0] {
    SMBSP_IDLE = 3'b000,  // Waiting for a start.
    SMBSP_ADDR = 3'b001,  // Shifting in the address byte.
    SMBSP_ACK  = 3'b010,  // Driving or ending an acknowledge slot.
    SMBSP_WR   = 3'b011,  // Shifting in a written byte.
    SMBSP_RD   = 3'b100,  // Shifting out a read byte.
    SMBSP_RACK = 3'b101,  // Sampling the master acknowledge.
    SMBSP_WAIT = 3'b110   // Not addressed, read ended by a nack or check byte refused; released until a start or stop.
  } smbsp_dev_state_t;

  typedef struct packed {
    logic [1:0]                sclS;     // Clock synchroniser, [0] is the first stage.
    logic [1:0]                sdaS;     // Data synchroniser, [0] is the first stage.
    logic                      sclD;     // Previous synchronised clock.
    logic                      sdaD;     // Previous synchronised data.
    smbsp_dev_state_t          st;
    logic [3:0]                bitCnt;   // Bits moved in the current byte.
    logic [1:0]                byteIdx;  // Data bytes after the address, saturating.
    logic [7:0]                shift;
    logic                      rw;       // Transfer direction.
    logic                      ara;      // Answering the alert response address.
    logic [7:0]                ptr;      // Address pointer.
    logic [7:0]                crc;      // Running check value.
    logic                      sdaLow;   // Pull data low.
    logic [TW-1:0]             idle;     // Cycles without bus activity.
    logic [7:0]                cfg;
    logic [7:0]                status;
    logic [7:0]                mask;
    logic                      alert;
    logic [REG_COUNT-1:0][7:0] regs;
  } smbsp_dev_t;

  smbsp_dev_t r;       // Registered state.
  smbsp_dev_t next_r;  // Next state.

  // Byte seen by a read at the given pointer.
  function automatic logic [7:0] readReg(input smbsp_dev_t s, input logic [7:0] p);
    logic [7:0] v;
    v = 8'h00;
    if (p == CFG_OFS) begin
      v = s.cfg;
    end else if (p == STATUS_OFS) begin
      v = s.status;
    end else if (p == MASK_OFS) begin
      v = s.mask;
    end else if (p < 8'(REG_COUNT)) begin
      v = s.regs[p[IW-1:0]];
    end
    return v;
  endfunction

  logic       sclRise;
  logic       sclFall;
  logic       startSeen;
  logic       stopSeen;
  logic       tmoHit;
  logic [7:0] crcIn;
  logic [7:0] txByte;
  logic [7:0] clrMask;

  // Next-state logic of the whole port.
  always_comb begin
    next_r  = r;
    clrMask = 8'h00;
    next_r.sclS = {r.sclS[0], bus.scl};  // R15
    next_r.sdaS = {r.sdaS[0], bus.sda};
    next_r.sclD = r.sclS[1];
    next_r.sdaD = r.sdaS[1];
    sclRise   = r.sclS[1] & ~r.sclD;
    sclFall   = ~r.sclS[1] & r.sclD;
    startSeen = r.sclS[1] & r.sclD & r.sdaD & ~r.sdaS[1];  // R1
    stopSeen  = r.sclS[1] & r.sclD & ~r.sdaD & r.sdaS[1];
    crcIn     = crc8(r.crc, r.shift);
    // The next outgoing byte: own address for the alert response, data, then the check byte.
    if (r.byteIdx == 2'd0) begin
      txByte = r.ara ? {DEV_ADDR, 1'b0} : readReg(r, r.ptr);  // R18 R20
    end else if (r.byteIdx == 2'd1) begin
      txByte = r.crc;  // R10 R11
    end else begin
      txByte = 8'hFF;
    end

    // Silence counter; any edge on either line counts as activity.
    if (r.st == SMBSP_IDLE || sclRise || sclFall || (r.sdaS[1] != r.sdaD)) begin
      next_r.idle = '0;
    end else if (r.idle != TW'(TIMEOUT_CYCLES - 1)) begin
      next_r.idle = r.idle + 1'b1;
    end
    tmoHit = ~r.cfg[TMO_DIS_BIT] && (r.idle == TW'(TIMEOUT_CYCLES - 1));  // R8 R9

    if (startSeen) begin
      // A start, repeated or not, begins a fresh address byte and check value.
      next_r.st      = SMBSP_ADDR;  // R1
      next_r.bitCnt  = 4'd0;
      next_r.byteIdx = 2'd0;
      next_r.crc     = 8'h00;
      next_r.sdaLow  = 1'b0;
    end else if (stopSeen || tmoHit) begin
      next_r.st     = SMBSP_IDLE;  // R21
      next_r.sdaLow = 1'b0;        // R21
    end else begin
      case (r.st)
        SMBSP_ADDR, SMBSP_WR: begin
          if (sclRise && r.bitCnt != 4'd8) begin
            next_r.shift  = {r.shift[6:0], r.sdaS[1]};  // R2
            next_r.bitCnt = r.bitCnt + 4'd1;
          end else if (sclFall && r.bitCnt == 4'd8) begin
            next_r.bitCnt = 4'd0;
            next_r.crc    = crcIn;  // R11
            if (r.st == SMBSP_ADDR) begin
              // Own address either way, or the alert response address read while alerting.
              if (r.shift[7:1] == DEV_ADDR || (r.shift[7:1] == ARA_ADDR && r.shift[0] && r.alert)) begin  // R3 R20
                next_r.st     = SMBSP_ACK;
                next_r.sdaLow = 1'b1;  // R4
                next_r.rw     = r.shift[0];  // R6
                next_r.ara    = (r.shift[7:1] == ARA_ADDR);
              end else begin
                next_r.st = SMBSP_WAIT;  // R5
              end
            end else begin
              // Pointer first, then one data byte, then the optional check byte.
              if (r.byteIdx == 2'd0) begin
                next_r.ptr = r.shift;  // R7
              end else if (r.byteIdx == 2'd1) begin
                if (r.ptr == CFG_OFS) begin
                  next_r.cfg = r.shift;  // R9 R17
                end else if (r.ptr == MASK_OFS) begin
                  next_r.mask = r.shift;  // R17
                end else if (r.ptr != STATUS_OFS && r.ptr < 8'(REG_COUNT)) begin
                  next_r.regs[r.ptr[IW-1:0]] = r.shift;  // R17
                end
              end
              if (r.byteIdx != 2'd3) begin
                next_r.byteIdx = r.byteIdx + 2'd1;
              end
              // A bad check byte is refused with a released acknowledge.
              if (r.byteIdx != 2'd2 || crcIn == 8'h00) begin  // R10 R11
                next_r.st     = SMBSP_ACK;
                next_r.sdaLow = 1'b1;  // R4
              end else begin
                next_r.st = SMBSP_WAIT;
              end
            end
          end
        end
        SMBSP_ACK: begin
          // The acknowledge slot ends on the falling clock; a read then drives its first bit.
          if (sclFall) begin
            next_r.sdaLow = 1'b0;
            next_r.bitCnt = 4'd0;
            if (r.rw) begin
              next_r.st     = SMBSP_RD;  // R6
              next_r.shift  = txByte;  // R18
              next_r.sdaLow = ~txByte[7];  // R15
              next_r.crc    = crc8(r.crc, txByte);  // R11
              if (r.byteIdx != 2'd3) begin
                next_r.byteIdx = r.byteIdx + 2'd1;
              end
              if (r.byteIdx == 2'd0 && !r.ara && r.ptr == STATUS_OFS) begin
                clrMask = 8'hFF;  // Reading status clears conditions that have gone away.
              end
            end else begin
              next_r.st = SMBSP_WR;
            end
          end
        end
        SMBSP_RD: begin
          if (sclFall) begin
            if (r.bitCnt == 4'd7) begin
              next_r.sdaLow = 1'b0;
              next_r.st     = SMBSP_RACK;
            end else begin
              next_r.bitCnt = r.bitCnt + 4'd1;
              next_r.shift  = {r.shift[6:0], 1'b0};
              next_r.sdaLow = ~r.shift[6];
            end
          end
        end
        SMBSP_RACK: begin
          // A master acknowledge asks for another byte, such as the check byte.
          if (sclRise) begin
            next_r.st = r.sdaS[1] ? SMBSP_WAIT : SMBSP_ACK;  // R19 R10
          end
        end
        SMBSP_WAIT: begin
          next_r.sdaLow = 1'b0;  // R5
        end
        default: begin
          next_r.st     = SMBSP_IDLE;
          next_r.sdaLow = 1'b0;
        end
      endcase
    end
    // Live limit inputs win over a clear in the same cycle.
    next_r.status = (r.status & ~clrMask) | limitIn;  // R16
    next_r.alert  = |(next_r.status & ~next_r.mask);  // R12 R13
  end

  // State register.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r      <= '0;
      r.sclS <= 2'b11;
      r.sdaS <= 2'b11;
      r.sclD <= 1'b1;
      r.sdaD <= 1'b1;
      r.st   <= SMBSP_IDLE;
      r.cfg  <= CFG_RESET;  // R9
    end else begin
      r <= next_r;
    end
  end

  assign bus.sdaDevOut = 1'b0;      // R15
  assign bus.sdaDevOe  = r.sdaLow;  // R15
  assign bus.alertOut  = 1'b0;      // R14
  assign bus.alertOe   = r.alert;   // R14 R12
  assign cfgOut        = r.cfg;
endmodule // smbsp_device

// [rtl/smbsp_host.sv]
// Bus master that runs one serial transfer per command written over Avalon-MM.
`timescale 1ns/1ps
module smbsp_host
  import smbsp_pkg::*;
#(
  parameter int QUARTER = smbsp_pkg::QUARTER_CYC  // Cycles per quarter of a clock bit.
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  smbsp_if.host            bus,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest
);
  import smbsp_pkg::*;

  localparam int DW = $clog2(QUARTER + 1);

  typedef enum logic [1:0] {
    SMBSP_H_IDLE  = 2'b00,
    SMBSP_H_START = 2'b01,
    SMBSP_H_BIT   = 2'b10,
    SMBSP_H_STOP  = 2'b11
  } smbsp_host_state_t;

  typedef struct packed {
    smbsp_host_state_t st;
    logic [DW-1:0]     div;     // Quarter timer.
    logic [1:0]        q;       // Quarter within a bit.
    logic [3:0]        bitIdx;  // 0..7 data, 8 acknowledge.
    logic [1:0]        byteIdx;
    logic [1:0]        last;    // Index of the final byte.
    logic [6:0]        addr;
    logic [7:0]        ptr;
    logic [7:0]        data;
    logic              rd;
    logic              two;
    logic [7:0]        shift;
    logic [7:0]        crc;
    logic              nack;
    logic              pecErr;
    logic [7:0]        rdata;
    logic              sclLow;
    logic              sdaLow;
    logic [1:0]        sdaS;    // Data synchroniser, [0] first.
    logic [1:0]        alertS;  // Alert synchroniser, [0] first.
    logic              rdDone;  // Read data captured, answer this cycle.
    logic [31:0]       rdReg;
  } smbsp_host_t;

  smbsp_host_t r;       // Registered state.
  smbsp_host_t next_r;  // Next state.
  logic        tick;
  logic        isRx;
  logic [7:0]  txb;
  logic [7:0]  byteVal;
  logic        cmdWr;

  // Next-state logic for the bit engine and the register port.
  always_comb begin
    next_r        = r;
    next_r.sdaS   = {r.sdaS[0], bus.sda};
    next_r.alertS = {r.alertS[0], bus.alert_n};
    tick  = (r.div == DW'(QUARTER - 1));
    isRx  = r.rd && (r.byteIdx != 2'd0);  // R6
    // Byte to send: address, pointer, data, then the check byte.
    if (r.byteIdx == 2'd0) begin
      txb = {r.addr, r.rd};  // R2
    end else if (r.byteIdx == 2'd1) begin
      txb = r.ptr;
    end else if (r.byteIdx == 2'd2 && r.two) begin
      txb = r.data;
    end else begin
      txb = r.crc;  // R10 R11
    end
    byteVal = isRx ? r.shift : txb;
    cmdWr   = avs_write && avs_address == CMD_OFS && r.st == SMBSP_H_IDLE;

    if (r.st != SMBSP_H_IDLE) begin
      next_r.div = tick ? '0 : r.div + 1'b1;
      if (tick) begin
        next_r.q = r.q + 2'd1;
      end
    end
    case (r.st)
      SMBSP_H_IDLE: begin
        // A command starts only from idle; a busy host holds the bus master off.
        if (cmdWr) begin
          next_r.st      = SMBSP_H_START;
          next_r.div     = '0;
          next_r.q       = 2'd0;
          next_r.addr    = avs_writedata[CMD_ADDR_LSB +: 7];
          next_r.ptr     = avs_writedata[CMD_PTR_LSB +: 8];
          next_r.data    = avs_writedata[CMD_DATA_LSB +: 8];
          next_r.rd      = avs_writedata[CMD_READ_BIT];
          next_r.two     = avs_writedata[CMD_TWO_BIT] & ~avs_writedata[CMD_READ_BIT];
          next_r.last    = 2'd1 + 2'(avs_writedata[CMD_TWO_BIT] & ~avs_writedata[CMD_READ_BIT])
                           + 2'(avs_writedata[CMD_PEC_BIT]);
          next_r.byteIdx = 2'd0;
          next_r.bitIdx  = 4'd0;
          next_r.crc     = 8'h00;
          next_r.nack    = 1'b0;
          next_r.pecErr  = 1'b0;
        end
      end
      SMBSP_H_START: begin
        if (tick && r.q == 2'd0) begin
          next_r.sdaLow = 1'b1;  // R1
        end else if (tick && r.q == 2'd1) begin
          next_r.sclLow = 1'b1;
          next_r.st     = SMBSP_H_BIT;
          next_r.q      = 2'd0;
        end
      end
      SMBSP_H_BIT: begin
        if (tick && r.q == 2'd0) begin
          // Data changes only in the low half of the clock.
          if (r.bitIdx != 4'd8) begin
            next_r.sdaLow = ~isRx & ~txb[3'd7 - r.bitIdx[2:0]];
          end else begin
            next_r.sdaLow = isRx & (r.byteIdx != r.last);  // R19
          end
        end else if (tick && r.q == 2'd1) begin
          next_r.sclLow = 1'b0;
        end else if (tick && r.q == 2'd3) begin
          next_r.sclLow = 1'b1;
          if (r.bitIdx != 4'd8) begin
            next_r.shift  = {r.shift[6:0], r.sdaS[1]};
            next_r.bitIdx = r.bitIdx + 4'd1;
          end else begin
            next_r.bitIdx = 4'd0;
            next_r.crc    = crc8(r.crc, byteVal);  // R11
            if (isRx && r.byteIdx == 2'd1) begin
              next_r.rdata = r.shift;
            end
            if (isRx && r.byteIdx == 2'd2 && crc8(r.crc, r.shift) != 8'h00) begin
              next_r.pecErr = 1'b1;
            end
            if (!isRx && r.sdaS[1]) begin
              next_r.nack = 1'b1;
              next_r.st   = SMBSP_H_STOP;
            end else if (r.byteIdx == r.last) begin
              next_r.st = SMBSP_H_STOP;
            end else begin
              next_r.byteIdx = r.byteIdx + 2'd1;
            end
          end
        end
      end
      SMBSP_H_STOP: begin
        // Data low under a low clock, clock up, then data up forms the stop.
        if (tick && r.q == 2'd0) begin
          next_r.sdaLow = 1'b1;  // R19
        end else if (tick && r.q == 2'd1) begin
          next_r.sclLow = 1'b0;
        end else if (tick && r.q == 2'd2) begin
          next_r.sdaLow = 1'b0;
        end else if (tick && r.q == 2'd3) begin
          next_r.st = SMBSP_H_IDLE;
        end
      end
      default: begin
        next_r.st = SMBSP_H_IDLE;
      end
    endcase

    // Reads take one wait cycle so the answer comes from a flip-flop.
    next_r.rdDone = avs_read & ~r.rdDone;
    if (avs_read && !r.rdDone) begin
      next_r.rdReg = 32'h0000_0000;
      if (avs_address == HSTAT_OFS) begin
        next_r.rdReg[HS_BUSY_BIT]        = (r.st != SMBSP_H_IDLE);
        next_r.rdReg[HS_NACK_BIT]        = r.nack;
        next_r.rdReg[HS_PEC_BIT]         = r.pecErr;
        next_r.rdReg[HS_ALERT_BIT]       = ~r.alertS[1];  // R20
        next_r.rdReg[HS_RDATA_LSB +: 8]  = r.rdata;
      end
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r        <= '0;
      r.st     <= SMBSP_H_IDLE;
      r.sdaS   <= 2'b11;
      r.alertS <= 2'b11;
    end else begin
      r <= next_r;
    end
  end

  assign avs_waitrequest = (avs_read & ~r.rdDone)
                         | (avs_write & (avs_address == CMD_OFS) & (r.st != SMBSP_H_IDLE));
  assign avs_readdata    = r.rdReg;
  assign bus.sclOut      = 1'b0;
  assign bus.sclOe       = r.sclLow;
  assign bus.sdaHostOut  = 1'b0;
  assign bus.sdaHostOe   = r.sdaLow;
endmodule // smbsp_host

// [tb/smbsp_properties.sv]
// Concurrent checks on the open-drain wires between host and device.
`timescale 1ns/1ps
module smbsp_properties #(
  parameter int TMO = 2000  // Device inactivity limit in cycles.
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic scl,
  input wire logic sda,
  input wire logic sdaDevOe,
  input wire logic sdaDevOut,
  input wire logic alertOe,
  input wire logic alertOut,
  input wire logic alert_n,
  input wire logic tmoOff     // Device inactivity timeout switched off.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  int quiet;  // Cycles since the last wire edge.

  // Counts silence on the wires, which is what arms the device timeout.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) quiet <= 0;
    else quiet <= ($changed(scl) || $changed(sda)) ? 0 : quiet + 1;
  end

  a_ack_grab_low: assert property ($rose(sdaDevOe) |-> !scl)
    else $error("device took data line while clock high");
  // A release after a full silence is the timeout, which may fall while the clock is high.
  a_ack_free_low: assert property ($fell(sdaDevOe) && quiet < TMO |-> !scl)
    else $error("device freed data line while clock high");
  a_ack_holds_high: assert property ($rose(scl) |-> $stable(sdaDevOe)[*8])
    else $error("device data moved during clock high");
  a_start_released: assert property ($fell(sda) && scl && $past(scl) |-> !sdaDevOe[*8])
    else $error("device drove data right after start");
  a_data_open_drain: assert property (sdaDevOe |-> !sdaDevOut)
    else $error("device drove data line high");
  a_alert_open_drain: assert property (alertOe |-> !alertOut)
    else $error("device drove alert high");
  a_alert_wire_level: assert property (alert_n == !alertOe)
    else $error("alert wire level wrong");
  a_idle_released: assert property (quiet > TMO + 8 && !tmoOff |-> !sdaDevOe)
    else $error("device holds data after silence");
  cover property ($rose(sdaDevOe));
  cover property ($fell(alert_n));
  cover property ($fell(sda) && scl);
endmodule // smbsp_properties

// [tb/smbus_slave_register_port_tb.sv]
// Self-checking bench joining the host and device ends of the serial port.
`timescale 1ns/1ps
module smbus_slave_register_port_tb;
  import smbsp_pkg::*;
  logic        clk = 1'h0;
  logic        rst_b = 1'h0;
  logic        hostRst_b = 1'h1;  // Resets the host alone to cut a frame short.
  logic [3:0]  adr = 4'h0;
  logic        rd = 1'h0;
  logic        wr = 1'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat, rv;     // Read data and last value taken.
  logic        waitReq;
  logic [7:0]  lim = 8'h00;  // Out-of-limit sources.
  logic [7:0]  cfg, v;
  int          fails = 0, checks_done = 0, seed = 88;
  logic [63:0] q[$];         // Expected read value and mask.

  smbsp_if smbsp_if_i ();
  smbsp_host #(.QUARTER(16)) smbsp_host_i (.clk(clk), .rst_b(rst_b & hostRst_b), .bus(smbsp_if_i),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_readdata(rdat), .avs_waitrequest(waitReq));
  smbsp_device #(.TIMEOUT_CYCLES(2000)) smbsp_device_i (.clk(clk), .rst_b(rst_b),
    .bus(smbsp_if_i), .limitIn(lim), .cfgOut(cfg));
  smbsp_properties #(.TMO(2000)) smbsp_properties_i (.clk(clk), .rst_b(rst_b),
    .scl(smbsp_if_i.scl), .sda(smbsp_if_i.sda), .sdaDevOe(smbsp_if_i.sdaDevOe),
    .sdaDevOut(smbsp_if_i.sdaDevOut), .alertOe(smbsp_if_i.alertOe),
    .alertOut(smbsp_if_i.alertOut), .alert_n(smbsp_if_i.alert_n), .tmoOff(cfg[TMO_DIS_BIT]));

  // Clock at 40 MHz.
  always #12.5 clk = ~clk;

  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  // Takes the oldest note whenever read data is handed over.
  always @(posedge clk) begin
    if (rd && !waitReq && q.size() > 0) begin
      logic [63:0] e;
      e = q.pop_front();
      if (e[31:0] !== 32'h0) cmp("readdata", e[63:32] & e[31:0], rdat & e[31:0]);
    end
  end

  // One Avalon cycle; a read notes what it should return under mask m.
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [31:0] m);
    if (!w) q.push_back({d, m});
    @(posedge clk);
    adr <= a;
    wd  <= d;
    wr  <= w;
    rd  <= !w;
    do @(posedge clk); while (waitReq !== 1'h0);
    rv = rdat;
    wr <= 1'h0;
    rd <= 1'h0;
  endtask

  // Runs one serial transfer and waits, bounded, for the host to go idle.
  task automatic xf(input logic [6:0] a7, input logic r, t, p, input logic [7:0] ptr, dat);
    int n;
    n = 0;
    av(1'h1, CMD_OFS, {6'h00, p, t, r, a7, dat, ptr}, 32'h0);
    do begin
      av(1'h0, HSTAT_OFS, 32'h0, 32'h0);
      n++;
    end while (rv[HS_BUSY_BIT] !== 1'h0 && n < 4000);
    cmp("busy", 32'h0, {31'h0, rv[HS_BUSY_BIT]});
  endtask

  task automatic wrreg(input logic [7:0] ptr, d);
    xf(DEV_ADDR, 1'h0, 1'h1, 1'h0, ptr, d);
    av(1'h0, HSTAT_OFS, 32'h0, 32'h2);
  endtask

  task automatic rdreg(input logic [7:0] ptr, e);
    xf(DEV_ADDR, 1'h0, 1'h0, 1'h0, ptr, 8'h00);
    xf(DEV_ADDR, 1'h1, 1'h0, 1'h0, 8'h00, 8'h00);
    av(1'h0, HSTAT_OFS, {16'h0, e, 8'h00}, 32'hFF02);
  endtask

  // Resets the host alone in the device's first acknowledge, leaving data held low under a high clock.
  task automatic cut(input logic [31:0] e);
    av(1'h1, CMD_OFS, {6'h00, 3'b010, DEV_ADDR, 16'h0007}, 32'h0);
    wait (smbsp_if_i.sdaDevOe === 1'h1);
    @(posedge clk);
    hostRst_b <= 1'h0;
    @(posedge clk);
    hostRst_b <= 1'h1;
    repeat (1000) @(posedge clk);
    cmp("sdaHeld", 32'h0, {31'h0, smbsp_if_i.sda});
    repeat (1100) @(posedge clk);
    cmp("sdaAfterSilence", e, {31'h0, smbsp_if_i.sda});
  endtask

  task report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Main sequence; each register access speaks the full serial protocol.
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'h1;
    rdreg(CFG_OFS, CFG_RESET);
    cmp("cfgOut", {24'h0, CFG_RESET}, {24'h0, cfg});
    $display("test reset values done");
    for (int i = 3; i < 6; i++) begin
      v = 8'($random(seed));
      wrreg(i[7:0], v);
      rdreg(i[7:0], v);
    end
    $display("test write read done");
    xf(DEV_ADDR ^ (7'h01 << ($unsigned($random(seed)) % 6)), 1'h0, 1'h1, 1'h0, 8'h05, ~v);
    av(1'h0, HSTAT_OFS, 32'h2, 32'h2);
    rdreg(8'h05, v);
    $display("test foreign address done");
    wrreg(MASK_OFS, 8'hFF);
    lim <= 8'h01;
    av(1'h0, HSTAT_OFS, 32'h0, 32'h8);
    wrreg(MASK_OFS, 8'h00);
    av(1'h0, HSTAT_OFS, 32'h8, 32'h8);
    xf(ARA_ADDR, 1'h1, 1'h0, 1'h0, 8'h00, 8'h00);
    av(1'h0, HSTAT_OFS, 32'h9800, 32'hFF02);
    lim <= 8'h00;
    rdreg(STATUS_OFS, 8'h01);
    av(1'h0, HSTAT_OFS, 32'h0, 32'h8);
    $display("test alert done");
    xf(DEV_ADDR, 1'h0, 1'h1, 1'h1, 8'h06, v);
    av(1'h0, HSTAT_OFS, 32'h0, 32'h2);
    xf(DEV_ADDR, 1'h1, 1'h0, 1'h1, 8'h00, 8'h00);
    av(1'h0, HSTAT_OFS, {16'h0, v, 8'h00}, 32'hFF06);
    $display("test check byte done");
    cut(32'h1);
    $display("test timeout done");
    wrreg(CFG_OFS, 8'h20);
    cmp("cfgOut", 32'h20, {24'h0, cfg});
    cut(32'h0);
    $display("test timeout disable done");
    report_and_stop;
  end

  // Cuts a hang short well past the expected run length.
  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    report_and_stop;
  end
endmodule // smbus_slave_register_port_tb
